// [include/iox_consts.svh]
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

// ----------------------------------------------------------------
// Port space split
// ----------------------------------------------------------------
`define IOX_RESERVED_TOP    8'h3f
`define IOX_GROUP_MSB       5
`define IOX_GROUP_LSB       3
`define IOX_GROUP_CARD_B    3'h4
`define IOX_GROUP_CARD_A    3'h5
`define IOX_GROUP_SHARED    3'h7
`define IOX_NO_GROUP        8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOX_CLK_PERIOD_NS   5
`define IOX_STROBE_NS       150
`define IOX_STROBE_CYC \
    ((`IOX_STROBE_NS + `IOX_CLK_PERIOD_NS - 1) / `IOX_CLK_PERIOD_NS)

`endif

// [include/iox_pkg.sv]
package iox_pkg;

    typedef enum logic [1:0]
    {
        IOX_IDLE   = 2'b00,
        IOX_SETUP  = 2'b01,
        IOX_STROBE = 2'b10,
        IOX_HOLD   = 2'b11
    } iox_state_e;

    typedef logic [7:0] iox_byte_t;

endpackage

// [include/iox_sel_if.sv]
`timescale 1ns/1ps

interface iox_sel_if;
    logic       start;
    logic       finish;
    logic [7:0] addr;
    logic [7:0] groupSelN;

    modport ctrl
    (
        output start,
        output finish,
        output addr,
        input  groupSelN
    );

    modport dec
    (
        input  start,
        input  finish,
        input  addr,
        output groupSelN
    );
endinterface

// [src/iox_bus_ctrl.sv]
`timescale 1ns/1ps
`include "iox_consts.svh"

// What this block does
// R1: Only ports 00h-3Fh are decoded inside; everything above is left alone.
// R2: Reserved range splits into eight active-low selects of eight ports each.
// R3: Each group select is gated with a strobe into per-group port enables.
// R4: Cards decode the low eight address lines and live at 40h-FFh.
// R5: Cards never answer port accesses from 00h to 3Fh; header cards get group selects there (card A 28h-2Fh, card B 20h-27h).
// R6: The card bus is for port expansion; memory cycles never select groups.
// R7: Shared read and write strobes, told apart by memory and port qualifiers.
// R8: Both headers get three address lines, data, strobes, selects, irq, wait.
// R9: A low wait request stretches the strobe until the card lets go.
module iox_bus_ctrl
    import iox_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       reqValid,
    output logic            reqReady,
    input  wire logic       reqWrite,
    input  wire logic       reqMem,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0] reqWdata,
    output logic            respDone,
    output logic [7:0]      respRdata,
    output logic [7:0]      groupSelN,
    output logic [7:0]      portRdEnN,
    output logic [7:0]      portWrEnN,
    output logic [7:0]      busAddr,
    input  wire logic [7:0] busDataIn,
    output logic [7:0]      busDataOut,
    output logic            busDataOe,
    output logic            readStrobeN,
    output logic            writeStrobeN,
    output logic            memoryCycleN,
    output logic            ioCycleN,
    input  wire logic       busWaitN,
    input  wire logic       busIrqN,
    output logic            busIrqPendN,
    output logic            cardClk,
    output logic            cardResetN,
    output logic [2:0]      lowPortAddr,
    output logic            ioReadStrobeN,
    output logic            ioWriteStrobeN,
    output logic            cardAGroupSelN,
    output logic            cardBGroupSelN,
    output logic            sharedTopGroupSelN,
    input  wire logic       cardAIrqN,
    input  wire logic       cardBIrqN,
    output logic            cardAIrqPendN,
    output logic            cardBIrqPendN,
    input  wire logic       cardAWaitN,
    input  wire logic       cardBWaitN
);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    localparam logic [7:0] STROBE_CYC = 8'(`IOX_STROBE_CYC);
    iox_state_e state;
    logic [7:0] strobeCnt;
    logic       isWrite;
    logic       isMem;
    logic       accept;
    logic       strobeOn;
    logic       strobeOff;
    logic       waitActive;
    logic       anyStrobeN;

    iox_sel_if sel ();
    iox_sel_decode uDecode
    (
        .clk   (clk),
        .rst_n (rst_n),
        .sel   (sel)
    );

    assign accept     = reqValid && reqReady;
    // Any card may hold the cycle, whichever header it sits on
    assign waitActive = !busWaitN || !cardAWaitN || !cardBWaitN;
    assign strobeOn   = (state == IOX_SETUP);
    assign strobeOff  = (state == IOX_STROBE) && (strobeCnt == 8'h00)
                        && !waitActive;                               // R9
    assign anyStrobeN = readStrobeN && writeStrobeN;
    assign sel.start  = accept && !reqMem;                            // R6
    assign sel.finish = (state == IOX_HOLD);
    assign sel.addr   = reqAddr[7:0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= IOX_IDLE;
            strobeCnt <= 8'h00;
        end
        else
        begin
            case (state)
                IOX_IDLE:
                    if (accept)
                        state <= IOX_SETUP;
                IOX_SETUP:
                begin
                    state     <= IOX_STROBE;
                    strobeCnt <= STROBE_CYC - 8'h01;
                end
                IOX_STROBE:
                    if (strobeCnt != 8'h00)
                        strobeCnt <= strobeCnt - 8'h01;
                    else if (!waitActive)
                        state <= IOX_HOLD;                            // R9
                IOX_HOLD:
                    state <= IOX_IDLE;
                default:
                    state <= IOX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request handshake and captured cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reqReady   <= 1'b1;
            isWrite    <= 1'b0;
            isMem      <= 1'b0;
            busAddr    <= 8'h00;
            lowPortAddr <= 3'h0;
            busDataOut <= 8'h00;
        end
        else if (accept)
        begin
            reqReady    <= 1'b0;
            isWrite     <= reqWrite;
            isMem       <= reqMem;
            busAddr     <= reqAddr[7:0];
            lowPortAddr <= reqAddr[2:0];                              // R8
            busDataOut  <= reqWdata;
        end
        else if (state == IOX_HOLD)
            reqReady <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            respDone  <= 1'b0;
            respRdata <= 8'h00;
        end
        else
        begin
            respDone <= strobeOff;
            if (strobeOff && !isWrite)
                respRdata <= busDataIn;
        end
    end

    // ------------------------------------------------------------
    // Qualifiers, data drive and strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memoryCycleN <= 1'b1;
            ioCycleN     <= 1'b1;
            busDataOe    <= 1'b0;
        end
        else if (accept)
        begin
            memoryCycleN <= !reqMem;                                  // R7
            ioCycleN     <= reqMem;                                   // R7
            busDataOe    <= reqWrite;
        end
        else if (state == IOX_HOLD)
        begin
            memoryCycleN <= 1'b1;
            ioCycleN     <= 1'b1;
            busDataOe    <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readStrobeN    <= 1'b1;
            writeStrobeN   <= 1'b1;
            ioReadStrobeN  <= 1'b1;
            ioWriteStrobeN <= 1'b1;
        end
        else if (strobeOn)
        begin
            // Shared strobes serve both cycle kinds
            readStrobeN    <= isWrite;                                // R7
            writeStrobeN   <= !isWrite;                               // R7
            ioReadStrobeN  <= isWrite || isMem;                       // R6 R8
            ioWriteStrobeN <= !isWrite || isMem;                      // R6 R8
        end
        else if (strobeOff)
        begin
            readStrobeN    <= 1'b1;
            writeStrobeN   <= 1'b1;
            ioReadStrobeN  <= 1'b1;
            ioWriteStrobeN <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Group selects and per-group enables
    // ------------------------------------------------------------
    assign groupSelN          = sel.groupSelN;                        // R2
    assign cardAGroupSelN     = sel.groupSelN[`IOX_GROUP_CARD_A];     // R8
    assign cardBGroupSelN     = sel.groupSelN[`IOX_GROUP_CARD_B];     // R8
    assign sharedTopGroupSelN = sel.groupSelN[`IOX_GROUP_SHARED];     // R8

    // A bare select is too wide: it spans the whole cycle incl. setup
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            portRdEnN <= `IOX_NO_GROUP;
            portWrEnN <= `IOX_NO_GROUP;
        end
        else if (strobeOn)
        begin
            portRdEnN <= sel.groupSelN | {8{isWrite || isMem}};       // R3
            portWrEnN <= sel.groupSelN | {8{!isWrite || isMem}};      // R3
        end
        else if (strobeOff)
        begin
            portRdEnN <= `IOX_NO_GROUP;
            portWrEnN <= `IOX_NO_GROUP;
        end
    end

    // ------------------------------------------------------------
    // Clock and reset to the cards, interrupt lines from them
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cardClk       <= 1'b0;
            cardResetN    <= 1'b0;
            busIrqPendN   <= 1'b1;
            cardAIrqPendN <= 1'b1;
            cardBIrqPendN <= 1'b1;
        end
        else
        begin
            cardClk       <= !cardClk;
            cardResetN    <= 1'b1;
            busIrqPendN   <= busIrqN;
            cardAIrqPendN <= cardAIrqN;                               // R8
            cardBIrqPendN <= cardBIrqN;                               // R8
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reserved_only: assert property (@(posedge clk) disable iff (!rst_n) // R1
        groupSelN != `IOX_NO_GROUP |-> busAddr <= `IOX_RESERVED_TOP
            && !ioCycleN)
        else $error("group select outside reserved range");

    a_group_onehot: assert property (@(posedge clk) disable iff (!rst_n) // R2
        groupSelN != `IOX_NO_GROUP |-> $onehot(~groupSelN)
            && !groupSelN[busAddr[`IOX_GROUP_MSB:`IOX_GROUP_LSB]])
        else $error("wrong group selected");

    a_enable_gated: assert property (@(posedge clk) disable iff (!rst_n) // R3
        portRdEnN != `IOX_NO_GROUP |-> !ioReadStrobeN
            && ((~portRdEnN & groupSelN) == 8'h00))
        else $error("port enable without strobe and select");

    a_mem_no_group: assert property (@(posedge clk) disable iff (!rst_n) // R6
        !memoryCycleN |-> groupSelN == `IOX_NO_GROUP && ioReadStrobeN
            && ioWriteStrobeN)
        else $error("memory cycle touched port selects");

    a_strobe_qualified: assert property (@(posedge clk) // R7
        disable iff (!rst_n)
        !anyStrobeN |-> (memoryCycleN != ioCycleN))
        else $error("strobe without single qualifier");

    a_header_addr: assert property (@(posedge clk) disable iff (!rst_n) // R8
        !ioCycleN |-> lowPortAddr == busAddr[2:0])
        else $error("header address differs from bus");

    a_wait_extends: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (state == IOX_STROBE && strobeCnt == 8'h00 && waitActive)
            |=> !anyStrobeN && !respDone)
        else $error("cycle ended under wait");

    a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n) // R9
        $fell(anyStrobeN) |-> !anyStrobeN [*8] ##[22:1000] respDone)
        else $error("strobe too short or never ends");

endmodule

// [src/iox_sel_decode.sv]
`timescale 1ns/1ps
`include "iox_consts.svh"

module iox_sel_decode
    import iox_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    iox_sel_if.dec    sel
);

    // ------------------------------------------------------------
    // Group decode
    // ------------------------------------------------------------
    function automatic logic hitGroup(input iox_byte_t a,
                                      input logic [2:0] g);
        // Anything above the reserved range belongs to the cards
        hitGroup = (a <= `IOX_RESERVED_TOP) &&
                   (a[`IOX_GROUP_MSB:`IOX_GROUP_LSB] == g);
    endfunction

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : gGroup
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    sel.groupSelN[g] <= 1'b1;
                else if (sel.start)
                    sel.groupSelN[g] <= !hitGroup(sel.addr, 3'(g)); // R1 R2
                else if (sel.finish)
                    sel.groupSelN[g] <= 1'b1;
            end
        end
    endgenerate

endmodule

// [tb/io_select_expansion_bus_tb_top.sv]
`timescale 1ns/1ps
`include "iox_consts.svh"

module io_select_expansion_bus_tb_top
    import iox_pkg::*;
;
    typedef struct packed
    {
        logic        wr;
        logic        mem;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  sel;
        logic [7:0]  data;
        logic        chk;
    } iox_row_s;

    localparam int LAT = `IOX_STROBE_CYC + 2;

    logic clk, rst_n, reqValid, reqReady, reqWrite, reqMem, respDone;
    logic busDataOe, readStrobeN, writeStrobeN, memoryCycleN, ioCycleN;
    logic busWaitN, busIrqN, busIrqPendN, cardResetN, ioReadStrobeN, cardClk;
    logic ioWriteStrobeN, cardAGroupSelN, cardBGroupSelN, sharedTopGroupSelN;
    logic cardAIrqN, cardBIrqN, cardAIrqPendN, cardBIrqPendN;
    logic cardAWaitN, cardBWaitN, bad;
    logic [15:0] reqAddr;
    logic [7:0]  reqWdata, respRdata, groupSelN, portRdEnN, portWrEnN;
    logic [7:0]  busAddr, busDataIn, busDataOut, waitLen, obsSel, gotData;
    logic [6:0]  saw;
    logic [2:0]  lowPortAddr;
    int          lat, errCount, checksDone, cycles;
    iox_row_s    rows [18];

    iox_bus_ctrl i_iox_bus_ctrl
    (
        .clk, .rst_n, .reqValid, .reqReady, .reqWrite, .reqMem, .reqAddr,
        .reqWdata, .respDone, .respRdata, .groupSelN, .portRdEnN, .portWrEnN,
        .busAddr, .busDataIn, .busDataOut, .busDataOe, .readStrobeN,
        .writeStrobeN, .memoryCycleN, .ioCycleN, .busWaitN, .busIrqN,
        .busIrqPendN, .cardClk, .cardResetN, .lowPortAddr, .ioReadStrobeN,
        .ioWriteStrobeN, .cardAGroupSelN, .cardBGroupSelN, .sharedTopGroupSelN,
        .cardAIrqN, .cardBIrqN, .cardAIrqPendN, .cardBIrqPendN, .cardAWaitN,
        .cardBWaitN
    );

    iox_card_model i_iox_card_model
    (
        .clk, .rst_n, .busAddr, .busDataOut, .readStrobeN, .writeStrobeN,
        .ioCycleN, .cardAGroupSelN, .waitLen, .busDataIn, .busWaitN
    );

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // One whole transfer, watching the bus every cycle until done
    // ----------------------------------------------------------------
    task automatic xfer(input iox_row_s r);
        reqWrite <= r.wr;
        reqMem <= r.mem;
        reqAddr <= r.addr;
        reqWdata <= r.wdata;
        reqValid <= 1'b1;
        do @(posedge clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        lat = 0;
        obsSel = 8'hff;
        saw = '0;
        bad = 1'b0;
        do
        begin
            @(posedge clk);
            lat++;
            obsSel &= groupSelN;
            saw |= {busDataOe, !ioCycleN, !memoryCycleN, !ioWriteStrobeN,
                    !ioReadStrobeN, !writeStrobeN, !readStrobeN};
            if (portRdEnN !== (groupSelN | {8{readStrobeN}})
                || portWrEnN !== (groupSelN | {8{writeStrobeN}})
                || {sharedTopGroupSelN, cardAGroupSelN, cardBGroupSelN}
                   !== {groupSelN[7], groupSelN[5:4]}
                || (!ioCycleN && lowPortAddr !== busAddr[2:0])
                || (busDataOe && busDataOut !== r.wdata))
                bad = 1'b1;
        end
        while (respDone !== 1'b1 && lat < 200);
        gotData = respRdata;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Generous ceiling: about 100 transfers of some 40 cycles each
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errCount++;
            printVerdict();
        end
    end

    initial
    begin
        {rst_n, reqValid, reqWrite, reqMem, reqAddr, reqWdata} = '0;
        {busIrqN, cardAIrqN, cardBIrqN, cardAWaitN, cardBWaitN} = 5'h1f;
        waitLen = 8'h00;
        for (int g = 0; g < 8; g++)
            rows[g] = '{1'b0, 1'b0, 16'(8 * g + 3), 8'h00, ~(8'h01 << g),
                        8'(8 * g + 3) ^ 8'ha5, g == 5};
        rows[8] = '{1'b0, 1'b0, 16'h0040, 8'h00, 8'hff, 8'he5, 1'b1};
        rows[9] = '{1'b1, 1'b0, 16'h0085, 8'h3c, 8'hff, 8'h00, 1'b0};
        rows[10] = '{1'b0, 1'b0, 16'h0085, 8'h00, 8'hff, 8'h3c, 1'b1};
        rows[11] = '{1'b0, 1'b0, 16'h00ff, 8'h00, 8'hff, 8'h5a, 1'b1};
        rows[12] = '{1'b0, 1'b1, 16'h0010, 8'h00, 8'hff, 8'h00, 1'b0};
        rows[13] = '{1'b1, 1'b1, 16'h0028, 8'h77, 8'hff, 8'h00, 1'b0};
        rows[14] = '{1'b1, 1'b0, 16'h002c, 8'h11, 8'hdf, 8'h00, 1'b0};
        rows[15] = '{1'b0, 1'b0, 16'h0028, 8'h00, 8'hdf, 8'h8d, 1'b1};
        rows[16] = '{1'b0, 1'b0, 16'h002c, 8'h00, 8'hdf, 8'h11, 1'b1};
        rows[17] = '{1'b1, 1'b0, 16'h003f, 8'h9e, 8'h7f, 8'h00, 1'b0};
        repeat (10) @(posedge clk);
        check({groupSelN}, 8'hff);
        check({reqReady, readStrobeN, writeStrobeN, ioCycleN, memoryCycleN,
               busDataOe, respDone, cardResetN}, 8'hf8);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            xfer(rows[i]);
            check(8'(lat), 8'(LAT));
            check(obsSel, rows[i].sel);
            check({1'b0, saw}, {1'b0, rows[i].wr, !rows[i].mem, rows[i].mem,
                  rows[i].wr & !rows[i].mem, !rows[i].wr & !rows[i].mem,
                  rows[i].wr, !rows[i].wr});
            check({7'h00, bad}, 8'h00);
            if (rows[i].chk)
                check(gotData, rows[i].data);
        end
        // ----------------------------------------------------------------
        // Stretched cycles, interrupt lines, reset in mid-transfer
        // ----------------------------------------------------------------
        waitLen <= 8'd50;
        xfer(rows[10]);
        check(8'(lat >= 52 && lat <= 58), 8'h01);
        check(gotData, 8'h3c);
        waitLen <= 8'h00;
        cardBWaitN <= 1'b0;
        fork
            xfer(rows[4]);
            begin
                repeat (60) @(posedge clk);
                cardBWaitN <= 1'b1;
            end
        join
        check(8'(lat >= 58 && lat <= 64), 8'h01);
        {busIrqN, cardAIrqN, cardBIrqN} <= 3'b010;
        repeat (3) @(posedge clk);
        check({5'h00, busIrqPendN, cardAIrqPendN, cardBIrqPendN}, 8'h02);
        gotData = {7'h00, cardClk};
        @(posedge clk);
        check({7'h00, cardClk}, {7'h00, !gotData[0]});
        xfer(rows[14]);
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(groupSelN & portRdEnN, 8'hff);
        check({3'h0, readStrobeN, ioReadStrobeN, ioCycleN, reqReady,
               cardResetN}, 8'h1e);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        xfer(rows[15]);
        check(gotData, 8'h8d);
        printVerdict();
    end
endmodule

// [tb/iox_card_model.sv]
`timescale 1ns/1ps

module iox_card_model
    import iox_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] busAddr,
    input  wire logic [7:0] busDataOut,
    input  wire logic       readStrobeN,
    input  wire logic       writeStrobeN,
    input  wire logic       ioCycleN,
    input  wire logic       cardAGroupSelN,
    input  wire logic [7:0] waitLen,
    output logic [7:0]      busDataIn,
    output logic            busWaitN
);
    iox_byte_t  regs [256];
    logic [7:0] cnt;
    logic       hit;

    // Port cycles above the reserved range, or the header card's own group
    assign hit = !ioCycleN && (busAddr > 8'h3f || !cardAGroupSelN);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 256; i++)
                regs[i] <= 8'(i) ^ 8'ha5;
        end
        else if (hit && !writeStrobeN)
            regs[busAddr] <= busDataOut;
    end

    // Undriven lines flip each cycle, so a stale byte shows only on every other cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busDataIn <= 8'h00;
        else if (hit && !readStrobeN)
            busDataIn <= regs[busAddr];
        else
            busDataIn <= ~busDataIn;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt      <= 8'h00;
            busWaitN <= 1'b1;
        end
        else if (hit && (!readStrobeN || !writeStrobeN))
        begin
            cnt      <= cnt + 8'h01;
            busWaitN <= (cnt + 8'h01 >= waitLen);
        end
        else
        begin
            cnt      <= 8'h00;
            busWaitN <= 1'b1;
        end
    end
endmodule
